//--- pkg/dbc_map.svh
`ifndef DBC_MAP_SVH
`define DBC_MAP_SVH
// Register byte offsets on the APB slave
`define DBC_OFF_CTRL      12'h000
`define DBC_OFF_STAT      12'h004
`define DBC_OFF_IRQ_STAT  12'h008
`define DBC_OFF_IRQ_MASK  12'h00C
`define DBC_OFF_ACK_DATA  12'h010
// Control register fields
`define DBC_BIT_HALT      7
`define DBC_BIT_BREAKPOINT_ENABLE_FLAG     6
`define DBC_BIT_ACKEN     5
`define DBC_BIT_RSTREQ    0
`define DBC_CTRL_RESET    8'h00
`define DBC_CTRL_WMASK    8'hE1
// Opcode and acknowledge character
`define DBC_BREAK_OPCODE  8'h00
`define DBC_ACK_CHAR      8'hFF
// Interrupt status bits
`define DBC_IRQ_BREAK     0
`define DBC_IRQ_RESUME    1
`define DBC_IRQ_RSTDONE   2
`define DBC_IRQ_WIDTH     3
// Device reset sequence length in system clocks
`define DBC_RST_CYCLES    16
`endif

//--- pkg/dbc_pkg.sv
package dbc_pkg;
  // APB request as one bundle
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } dbc_apb_req_t;
  // Processor decode report
  typedef struct packed {
    logic       valid;
    logic [7:0] opcode;
  } dbc_decode_t;
  // Device reset sequencer states
  typedef enum logic [1:0] {
    DBC_RST_IDLE,
    DBC_RST_ASSERT,
    DBC_RST_DONE
  } dbc_rst_state_t;
endpackage

//--- src/dbc_reset_seq.sv
`timescale 1ns/1ps
`default_nettype none
module dbc_reset_seq #(
  parameter int CYCLES = 16
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic nrst,
  // Control
  input  wire logic start,
  output logic      dev_rst,
  output logic      done
);
  import dbc_pkg::*;

  dbc_rst_state_t state_q;
  dbc_rst_state_t state_d;
  logic [15:0]    cnt_q;
  logic [15:0]    cnt_d;
  wire            cnt_end = (cnt_q == 16'(CYCLES - 1));

  // Hold the device in reset for a fixed count, then signal completion
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      DBC_RST_IDLE: begin
        cnt_d = 16'h0000;
        if (start) begin
          state_d = DBC_RST_ASSERT;
        end
      end
      DBC_RST_ASSERT: begin
        cnt_d = cnt_q + 16'h0001;
        if (cnt_end) begin
          state_d = DBC_RST_DONE;
        end
      end
      DBC_RST_DONE: state_d = DBC_RST_IDLE;
      default:      state_d = DBC_RST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_q <= DBC_RST_IDLE;
      cnt_q   <= 16'h0000;
      dev_rst <= 1'b0;
      done    <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      dev_rst <= (state_d == DBC_RST_ASSERT);
      done    <= (state_d == DBC_RST_DONE);
    end
  end
endmodule
`default_nettype wire

//--- src/dbc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dbc_map.svh"
module dbc_top #(
  parameter int RST_CYCLES = `DBC_RST_CYCLES
) (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 nrst,
  // APB slave
  input  wire dbc_pkg::dbc_apb_req_t apb_req,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Processor decoder side
  input  wire dbc_pkg::dbc_decode_t decode,
  output logic                      fetch_stall,
  // Debugger host side
  input  wire logic                 read_protect,
  output logic                      ack_valid,
  output logic [7:0]                ack_char,
  input  wire logic                 ack_ready,
  // Device reset and interrupt
  output logic                      dev_rst,
  output logic                      irq
);
  import dbc_pkg::*;

  // Control register flops
  logic                      halt_q;
  logic                      breakpoint_enable_flag_q;
  logic                      acken_q;
  logic                      rstreq_q;

  // Interrupt status and mask flops
  logic [`DBC_IRQ_WIDTH-1:0] ist_q;
  logic [`DBC_IRQ_WIDTH-1:0] imask_q;

  // Acknowledge character still owed to the host
  logic                      ack_pend_q;

  // Reset sequencer outputs, declared ahead of every use
  wire                       dev_rst_w;
  wire                       rst_done;

  // Word-aligned address match helper
  // Byte lanes below bit 2 are ignored, so any byte of a word hits it
  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
    addr_is = (a[11:2] == off[11:2]);
  endfunction

  // Any register of the map
  // Used for the error response, so one list of offsets serves both
  function automatic logic addr_is_map(input logic [11:0] a);
    addr_is_map = addr_is(a, `DBC_OFF_CTRL) | addr_is(a, `DBC_OFF_STAT) |
                  addr_is(a, `DBC_OFF_IRQ_STAT) | addr_is(a, `DBC_OFF_IRQ_MASK) |
                  addr_is(a, `DBC_OFF_ACK_DATA);
  endfunction

  // APB phase decode
  // The slave answers at the setup edge, so the access phase has no wait states
  wire acc      = apb_req.psel & apb_req.penable;
  wire setup    = apb_req.psel & ~apb_req.penable;
  wire wr       = acc & apb_req.pwrite;
  wire rd_setup = setup & ~apb_req.pwrite;

  // Register hits, shared by the setup and the access phase
  // The master holds the address through both, so one decode suffices
  wire hit_ctrl = addr_is(apb_req.paddr, `DBC_OFF_CTRL);
  wire hit_stat = addr_is(apb_req.paddr, `DBC_OFF_STAT);
  wire hit_ist  = addr_is(apb_req.paddr, `DBC_OFF_IRQ_STAT);
  wire hit_imsk = addr_is(apb_req.paddr, `DBC_OFF_IRQ_MASK);
  wire hit_ack  = addr_is(apb_req.paddr, `DBC_OFF_ACK_DATA);
  wire mapped   = addr_is_map(apb_req.paddr);

  // Write strobes, taken at the access edge only
  // An unmapped write matches no strobe and so changes nothing
  wire wr_ctrl  = wr & hit_ctrl;
  wire wr_ist   = wr & hit_ist;
  wire wr_imsk  = wr & hit_imsk;
  wire [7:0] wb = apb_req.pwdata[7:0];

  // Break detection: only opcode 00H is the break
  // Any other opcode passes untouched, whatever the enables say
  wire is_break  = decode.valid & (decode.opcode == `DBC_BREAK_OPCODE);

  // With breakpoints off the break runs as a no-operation
  // Gated by the registered device reset, so the ignore window matches the pin
  wire break_hit = is_break & breakpoint_enable_flag_q & ~dev_rst;

  // Halt clear is refused under read protection
  // Only nrst, or a clear written once read_protect drops, can then release the processor
  wire halt_wr0  = wr_ctrl & ~wb[`DBC_BIT_HALT] & ~read_protect;
  wire halt_wr1  = wr_ctrl & wb[`DBC_BIT_HALT];

  // A break in the same cycle as a clear keeps the halt set
  // Losing that break would let the processor run past a breakpoint
  wire resume_ev = halt_q & halt_wr0 & ~break_hit;
  wire halt_d    = break_hit | halt_wr1 | (halt_q & ~halt_wr0);

  // A new request is taken only while no sequence runs
  // A second write of one during the sequence does not stretch it
  wire rst_start = wr_ctrl & wb[`DBC_BIT_RSTREQ] & ~rstreq_q;
  wire rstreq_d  = rst_start | (rstreq_q & ~rst_done);

  // Device reset sequencer
  // It drives only the device reset; debugger state stays as it is
  dbc_reset_seq #(
    .CYCLES (RST_CYCLES)
  ) i_dbc_reset_seq (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .start   (rst_start),
    .dev_rst (dev_rst_w),
    .done    (rst_done)
  );

  // Events into the sticky status
  // Set beats a write-one clear, so an event never slips between read and clear
  wire [`DBC_IRQ_WIDTH-1:0] ev    = {rst_done, resume_ev, break_hit};
  wire [`DBC_IRQ_WIDTH-1:0] iclr  = wr_ist ? wb[`DBC_IRQ_WIDTH-1:0] : '0;
  wire [`DBC_IRQ_WIDTH-1:0] ist_d = ev | (ist_q & ~iclr);

  // Interrupt level from the next status, so it is not a cycle late
  wire                      irq_d = |(ist_d & imask_q);

  // Read views; reserved control bits read zero
  // Reserved write bits have no flop at all, so nothing can leak back
  wire [7:0] ctrl_rd = {halt_q, breakpoint_enable_flag_q, acken_q, 4'h0, rstreq_q};
  wire [7:0] stat_rd = {halt_q, dev_rst_w, read_protect, ack_pend_q, 4'h0};

  // Read mux on the setup-phase address
  // Upper bits of every register read zero
  wire [31:0] rd_mux = hit_ctrl ? {24'h000000, ctrl_rd} :
                       hit_stat ? {24'h000000, stat_rd} :
                       hit_ist  ? {29'h0000000, ist_q} :
                       hit_imsk ? {29'h0000000, imask_q} :
                       hit_ack  ? {24'h000000, `DBC_ACK_CHAR} : 32'h00000000;

  // Answer launched at the setup edge
  // Trade-off: read data shows the state one edge before the access edge
  wire [31:0] prdata_d  = rd_setup ? rd_mux : 32'h00000000;
  wire        pslverr_d = setup & ~mapped;

  // Acknowledge character stays owed until the host link takes it
  // A second break while one is owed folds into the same character
  wire ack_set = break_hit & acken_q;
  wire ack_d   = ack_set | (ack_pend_q & ~ack_ready);

  // Halt flag; the device reset spares it
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      halt_q <= 1'b0;
    end else begin
      halt_q <= halt_d;
    end
  end

  // Enables change only on a control write
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      breakpoint_enable_flag_q <= 1'b0;
      acken_q <= 1'b0;
    end else if (wr_ctrl) begin
      breakpoint_enable_flag_q <= wb[`DBC_BIT_BREAKPOINT_ENABLE_FLAG];
      acken_q <= wb[`DBC_BIT_ACKEN];
    end
  end

  // Self-clearing request ends with the sequence
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rstreq_q <= 1'b0;
    end else begin
      rstreq_q <= rstreq_d;
    end
  end

  // Sticky status bits
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ist_q <= '0;
    end else begin
      ist_q <= ist_d;
    end
  end

  // Interrupt mask, same layout as the status
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      imask_q <= '0;
    end else if (wr_imsk) begin
      imask_q <= wb[`DBC_IRQ_WIDTH-1:0];
    end
  end

  // Owed acknowledge character
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ack_pend_q <= 1'b0;
    end else begin
      ack_pend_q <= ack_d;
    end
  end

  // APB answer, one cycle each
  // pready rises in the access cycle since the setup cycle launched it
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= pslverr_d;
      prdata  <= prdata_d;
    end
  end

  // Processor stall follows the halt flag
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      fetch_stall <= 1'b0;
    end else begin
      fetch_stall <= halt_d;
    end
  end

  // Host link outputs; the character is a constant while owed
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ack_valid <= 1'b0;
      ack_char  <= 8'h00;
    end else begin
      ack_valid <= ack_d;
      ack_char  <= ack_d ? `DBC_ACK_CHAR : 8'h00;
    end
  end

  // Device reset pin and interrupt level
  // The pin lags the sequencer by one edge to come straight from a flop
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      dev_rst <= 1'b0;
      irq     <= 1'b0;
    end else begin
      dev_rst <= dev_rst_w;
      irq     <= irq_d;
    end
  end

  // Limitation: the link that carries the character is outside this block
  // Limitation: a device reset does not clear the enables or the halt flag
  // Limitation: status reads show the sequencer, one edge ahead of the pin
endmodule
`default_nettype wire

//--- bench/dbc_checker_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "dbc_map.svh"
module dbc_checker #(
  parameter int RST_CYCLES = `DBC_RST_CYCLES
) (
  // Clock and reset
  input wire logic                  clk_sys,
  input wire logic                  nrst,
  // Watched ports
  input wire dbc_pkg::dbc_apb_req_t apb_req,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire dbc_pkg::dbc_decode_t  decode,
  input wire logic                  fetch_stall,
  input wire logic                  read_protect,
  input wire logic                  ack_valid,
  input wire logic [7:0]            ack_char,
  input wire logic                  dev_rst
);
  import dbc_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Control writes and break decodes as seen at the edge
  wire wr = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.paddr == `DBC_OFF_CTRL;
  wire clr = wr && !apb_req.pwdata[7];
  wire break_instruction = decode.valid && decode.opcode == `DBC_BREAK_OPCODE;
  logic en_q;
  // Shadow of the enable bit; a dev reset spares the debugger
  always_ff @(posedge clk_sys) begin
    if (!nrst) en_q <= 1'b0;
    else if (wr) en_q <= apb_req.pwdata[6];
  end
  property p_ack; ack_valid |-> ack_char == `DBC_ACK_CHAR; endproperty
  a_ack: assert property (p_ack) else $error("ack char");
  property p_hold; fetch_stall && !clr && !dev_rst |=> fetch_stall; endproperty
  a_hold: assert property (p_hold) else $error("halt lost");
  property p_prot; fetch_stall && read_protect && !dev_rst |=> fetch_stall; endproperty
  a_prot: assert property (p_prot) else $error("protected halt cleared");
  property p_run; fetch_stall && clr && !read_protect && !break_instruction |-> ##[1:2] !fetch_stall; endproperty
  a_run: assert property (p_run) else $error("no resume");
  property p_set; !fetch_stall && !break_instruction && !(wr && apb_req.pwdata[7]) |=> !fetch_stall; endproperty
  a_set: assert property (p_set) else $error("stray halt");
  property p_off; break_instruction && !en_q && !wr && !fetch_stall |=> !fetch_stall; endproperty
  a_off: assert property (p_off) else $error("break not ignored");
  property p_on; break_instruction && en_q && !dev_rst |=> fetch_stall; endproperty
  a_on: assert property (p_on) else $error("break missed");
  property p_len; $rose(dev_rst) |-> ##RST_CYCLES $fell(dev_rst); endproperty
  a_len: assert property (p_len) else $error("reset length");
  property p_rsv; pready && !apb_req.pwrite && apb_req.paddr == `DBC_OFF_CTRL |-> prdata[4:1] == 4'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
endmodule
bind dbc_top dbc_checker #(.RST_CYCLES(RST_CYCLES)) i_dbc_checker (.clk_sys(clk_sys), .nrst(nrst),
  .apb_req(apb_req), .prdata(prdata), .pready(pready), .decode(decode), .fetch_stall(fetch_stall),
  .read_protect(read_protect), .ack_valid(ack_valid), .ack_char(ack_char), .dev_rst(dev_rst));
`default_nettype wire

//--- bench/dbc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module dbc_host_model (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  // Acknowledge link
  input  wire logic       ack_valid,
  input  wire logic [7:0] ack_char,
  output logic            ack_ready,
  // Bench control and record
  input  wire logic       slow,
  output var int          char_count
);
  // A slow host holds off so the character must wait
  assign ack_ready = !slow;
  // Only the acknowledge value counts, so a wrong character shows
  always_ff @(posedge clk_sys) begin
    if (!nrst) char_count <= 0;
    else if (ack_valid && ack_ready && ack_char == 8'hFF) char_count <= char_count + 1;
  end
endmodule
`default_nettype wire

//--- bench/dbc_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "dbc_map.svh"
module dbc_top_test;
  import dbc_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  dbc_apb_req_t req = '0;
  dbc_decode_t dec = '0;
  logic rp = 1'b0;
  logic slow = 1'b0;
  logic [31:0] prdata, q;
  logic [7:0] ack_char;
  logic pready, pslverr, serr, stall, ack_valid, ack_ready, dev_rst, irq;
  int char_count;
  int errors = 0;
  int cmp_count = 0;
  always #12.5 clk_sys = ~clk_sys;
  dbc_top #(.RST_CYCLES(4)) i_dbc_top (.clk_sys(clk_sys), .nrst(nrst), .apb_req(req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .decode(dec), .fetch_stall(stall), .read_protect(rp), .irq(irq),
    .ack_valid(ack_valid), .ack_char(ack_char), .ack_ready(ack_ready), .dev_rst(dev_rst));
  dbc_host_model i_dbc_host_model (.clk_sys(clk_sys), .nrst(nrst), .ack_valid(ack_valid),
    .ack_char(ack_char), .ack_ready(ack_ready), .slow(slow), .char_count(char_count));
  task automatic report_and_stop;
    $display("compares %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // One transfer; the request stands until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_sys);
    req.penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    serr = pslverr;
    req <= '0;
    if (pready !== 1'b1) begin
      errors++;
      report_and_stop;
    end
  endtask
  // One-cycle decode report from the processor
  task automatic op(input logic [7:0] c);
    @(posedge clk_sys);
    dec <= '{1'b1, c};
    @(posedge clk_sys);
    dec <= '0;
    idle(2);
  endtask
  // Main sequence
  initial begin
    idle(4);
    nrst <= 1'b1;
    apb(1'b0, `DBC_OFF_CTRL, 32'h0);
    chk(q, 32'h0);
    apb(1'b1, `DBC_OFF_CTRL, 32'h1E);
    apb(1'b0, `DBC_OFF_CTRL, 32'h0);
    chk(q, 32'h0);
    op(8'h00);
    chk(stall, 1'b0);
    apb(1'b1, `DBC_OFF_CTRL, 32'h60);
    op(8'h01);
    chk(stall, 1'b0);
    slow <= 1'b1;
    op(8'h00);
    chk({stall, ack_valid, irq}, 3'b110);
    apb(1'b0, `DBC_OFF_CTRL, 32'h0);
    chk(q, 32'hE0);
    apb(1'b0, `DBC_OFF_STAT, 32'h0);
    chk(q, 32'h90);
    apb(1'b0, `DBC_OFF_ACK_DATA, 32'h0);
    chk(q, 32'hFF);
    apb(1'b1, `DBC_OFF_IRQ_MASK, 32'h1);
    idle(2);
    chk(irq, 1'b1);
    slow <= 1'b0;
    idle(2);
    chk(char_count, 1);
    rp <= 1'b1;
    apb(1'b1, `DBC_OFF_CTRL, 32'h60);
    idle(2);
    chk(stall, 1'b1);
    rp <= 1'b0;
    apb(1'b1, `DBC_OFF_CTRL, 32'h60);
    idle(2);
    chk(stall, 1'b0);
    op(8'h5A);
    chk(stall, 1'b0);
    apb(1'b1, `DBC_OFF_IRQ_STAT, 32'h7);
    idle(2);
    chk(irq, 1'b0);
    apb(1'b0, 12'hFFC, 32'h0);
    chk({31'h0, serr}, 32'h1);
    chk(q, 32'h0);
    apb(1'b1, `DBC_OFF_CTRL, 32'h61);
    idle(2);
    chk(dev_rst, 1'b1);
    for (int i = 0; i < 20 && dev_rst !== 1'b0; i++) @(posedge clk_sys);
    chk(dev_rst, 1'b0);
    apb(1'b0, `DBC_OFF_CTRL, 32'h0);
    chk(q, 32'h60);
    apb(1'b0, `DBC_OFF_IRQ_STAT, 32'h0);
    chk(q, 32'h4);
    report_and_stop;
  end
endmodule
`default_nettype wire
